// ==== dv/dtc_core_model.sv ====
`timescale 1ns/100ps
// processor core: register strobes and interrupt-serviced pulses
module dtc_core_model (
   input  wire logic       clk,        // clock
   output logic      [7:0] sfr_addr,   // address
   output logic            sfr_wr,     // write strobe
   output logic            sfr_rd,     // read strobe
   output logic      [7:0] sfr_wdata,  // write data
   input  wire logic [7:0] sfr_rdata,  // read data
   output logic      [3:0] ack         // serviced: u0, u1, x0, x1
);
   // idle bus at time zero
   initial begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      ack = 4'h0;
   end
   // one-cycle write, then scramble the idle bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      sfr_addr <= ~a;
      sfr_wdata <= ~d;
   endtask
   // one-cycle read, data taken at the following edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sfr_addr <= a;
      sfr_rd <= 1'b1;
      @(posedge clk);
      sfr_rd <= 1'b0;
      sfr_addr <= ~a;
      @(posedge clk);
      d = sfr_rdata;
   endtask
   // one serviced pulse per interrupt source
   task automatic pulse(input int i);
      @(posedge clk);
      ack[i] <= 1'b1;
      @(posedge clk);
      ack[i] <= 1'b0;
   endtask
endmodule

// ==== dv/dtc_timer_chk.sv ====
`timescale 1ns/100ps
// watches the register port, the two external interrupt pins and the four request flags
module dtc_timer_chk (
   input wire logic       clk,                  // clock
   input wire logic       rst,                  // sync reset
   input wire logic [7:0] sfr_addr,             // address
   input wire logic       sfr_wr,               // write strobe
   input wire logic       sfr_rd,               // read strobe
   input wire logic [7:0] sfr_wdata,            // write data
   input wire logic [7:0] sfr_rdata,            // read data
   input wire logic       ext_irq_in0,          // ext pin 0
   input wire logic       ext_irq_in1,          // ext pin 1
   input wire logic       ack_unit0,            // unit-0 serviced
   input wire logic       ack_unit1,            // unit-1 serviced
   input wire logic       ack_ext1,             // ext 1 serviced
   input wire logic       unit0_overflow_flag,  // unit-0 flag
   input wire logic       unit1_overflow_flag,  // unit-1 flag
   input wire logic       ext_irq0_flag,        // ext 0 flag
   input wire logic       ext_irq1_flag         // ext 1 flag
);
   logic [7:0] mode_q;    // shadow of timer_mode
   logic [3:0] ctl_q;     // shadow of run1, run0, type1, type0
   logic [7:0] ctl_view;  // expected control read image
   logic       rd_ctl;    // read of timer_control
   logic       rd_mode;   // read of timer_mode
   logic       rd_none;   // read of an unmapped address
   assign ctl_view = {unit1_overflow_flag, ctl_q[3], unit0_overflow_flag,
                      ctl_q[2], ext_irq1_flag, ctl_q[1], ext_irq0_flag,
                      ctl_q[0]};
   assign rd_ctl = sfr_rd && sfr_addr == 8'h88;
   assign rd_mode = sfr_rd && sfr_addr == 8'h89;
   assign rd_none = sfr_rd && (sfr_addr < 8'h88 || sfr_addr > 8'h8d);
   // mirror writable bits as the bus writes them
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_q <= 8'h00;
         ctl_q  <= 4'h0;
      end else if (sfr_wr && sfr_addr == 8'h89) begin
         mode_q <= sfr_wdata;
      end else if (sfr_wr && sfr_addr == 8'h88) begin
         ctl_q <= {sfr_wdata[6], sfr_wdata[4], sfr_wdata[2], sfr_wdata[0]};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   read_ctl_a: assert property (
      $past(rd_ctl) |-> sfr_rdata == $past(ctl_view))
      else $error("control read image wrong");
   read_mode_a: assert property ($past(rd_mode) |->
      sfr_rdata == $past(mode_q)) else $error("mode read wrong");
   unmapped_rd_a: assert property ($past(rd_none) |->
      sfr_rdata == 8'h00) else $error("unmapped read not zero");
   fall_u0_a: assert property ($fell(unit0_overflow_flag) |->
      $past(ack_unit0)) else $error("unit-0 flag dropped unasked");
   fall_u1_a: assert property ($fell(unit1_overflow_flag) |->
      $past(ack_unit1)) else $error("unit-1 flag dropped unasked");
   off_u0_a: assert property (!ctl_q[2] && !$past(ctl_q[2]) &&
      !unit0_overflow_flag |=> !unit0_overflow_flag)
      else $error("unit-0 flag set while stopped");
   off_u1_a: assert property (!ctl_q[3] && !$past(ctl_q[3]) &&
      !unit1_overflow_flag |=> !unit1_overflow_flag)
      else $error("unit-1 flag set while stopped");
   ack_u0_a: assert property (ack_unit0 && !ctl_q[2] &&
      !$past(ctl_q[2]) |=> !unit0_overflow_flag)
      else $error("unit-0 ack did not clear");
   level_x0_a: assert property ((!ctl_q[0] && !ext_irq_in0)[*4] |->
      ext_irq0_flag) else $error("low level not flagged");
   edge_x1_a: assert property ((ctl_q[1] && !ext_irq_in1)[*6] ##0
      ack_ext1 |=> !ext_irq1_flag) else $error("edge mode re-set");
   cover property (unit0_overflow_flag && ack_unit0);
   cover property ($rose(unit1_overflow_flag));
   cover property (rd_ctl);
endmodule
bind dtc_timer_top dtc_timer_chk u_chk (.clk, .rst, .sfr_addr, .sfr_wr,
   .sfr_rd, .sfr_wdata, .sfr_rdata, .ext_irq_in0, .ext_irq_in1, .ack_unit0,
   .ack_unit1, .ack_ext1, .unit0_overflow_flag, .unit1_overflow_flag,
   .ext_irq0_flag, .ext_irq1_flag);

// ==== dv/testbench.sv ====
`timescale 1ns/100ps
module testbench;
   localparam int OSC = 6;         // shortened sample period
   logic        clk, rst;          // clock and reset
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, rv;  // bus, read value
   logic        sfr_wr, sfr_rd;    // strobes
   logic        count_pin0, count_pin1, ext_irq_in0, ext_irq_in1;  // pins
   logic [3:0]  ack, flg;          // serviced pulses, flags u0 u1 x0 x1
   logic [16:0] e;                 // expected {ovf, high, low}
   logic [31:0] r;                 // random word
   logic [15:0] v;                 // start count
   int          num_errors, n_tests, cyc, n;
   integer      seed = 32'h2686;   // fixed seed
   dtc_timer_top #(.OSC_DIV(OSC)) DUT (.clk, .rst, .sfr_addr, .sfr_wr,
      .sfr_rd, .sfr_wdata, .sfr_rdata, .count_pin0, .count_pin1,
      .ext_irq_in0, .ext_irq_in1, .ack_unit0(ack[0]), .ack_unit1(ack[1]),
      .ack_ext0(ack[2]), .ack_ext1(ack[3]), .unit0_overflow_flag(flg[0]),
      .unit1_overflow_flag(flg[1]), .ext_irq0_flag(flg[2]),
      .ext_irq1_flag(flg[3]));
   dtc_core_model core (.clk, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
      .sfr_rdata, .ack);
   // one count step of a unit in modes 0 to 2
   function automatic logic [16:0] step(input int m, input logic [15:0] x);
      logic [12:0] c;
      c = {x[15:8], x[4:0]} + 13'h1;
      if (m == 0) step = {c == 13'h0, c[12:5], x[7:5], c[4:0]};
      else if (m == 1) step = {x == 16'hffff, x + 16'h1};
      else step = {x[7:0] == 8'hff, x[15:8],
                   (x[7:0] == 8'hff) ? x[15:8] : x[7:0] + 8'h1};
   endfunction
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // bounded wait for one flag
   task automatic wait_flag(input int i, input int lim, output int k);
      k = 0;
      while (flg[i] !== 1'b1 && k < lim) begin
         @(posedge clk);
         k++;
      end
   endtask
   // 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // ceiling well above the fewer than a thousand cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      rst = 1'b1;
      {count_pin0, count_pin1, ext_irq_in0, ext_irq_in1} = 4'hf;
      num_errors = 0;
      n_tests = 0;
      cyc = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int a = 8'h86; a < 8'h90; a++) begin
         core.rd(8'(a), rv);
         check(rv, 8'h00);
      end
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         core.wr(8'h89, r[7:0] & 8'hfe);
         core.rd(8'h89, rv);
         check(rv, r[7:0] & 8'hfe);
         core.wr(8'h88, (r[15:8] & 8'h05) | 8'haa);
         core.rd(8'h88, rv);
         check(rv, r[15:8] & 8'h05);
         core.wr(8'(8'h8a + k), r[23:16]);
         core.rd(8'(8'h8a + k), rv);
         check(rv, r[23:16]);
         core.wr(8'(8'h87 + 7 * k[0]), 8'hff);
         core.rd(8'(8'h87 + 7 * k[0]), rv);
         check(rv, 8'h00);
      end
      core.wr(8'h88, 8'h00);
      $display("done: registers");
      for (int u = 0; u < 2; u++) begin
         for (int m = 0; m < 3; m++) begin
            r = $random(seed);
            v = {(m == 2) ? r[15:8] : 8'hff, (m == 0) ? r[7:5] : 3'h7, 5'h1e};
            e = step(m, v);
            e = step(m, e[15:0]);
            core.wr(8'h89, 8'(m << (4 * u)));
            core.wr(8'(8'h8a + u), v[7:0]);
            core.wr(8'(8'h8c + u), v[15:8]);
            core.wr(8'h88, u ? 8'h40 : 8'h10);
            wait_flag(u, 3 * OSC, n);
            core.wr(8'h88, 8'h00);
            check(flg[u], 1'b1);
            check(8'(n >= OSC + 1 && n <= 2 * OSC + 2), 8'h01);
            core.rd(8'(8'h8a + u), rv);
            check(rv, e[7:0]);
            core.rd(8'(8'h8c + u), rv);
            check(rv, e[15:8]);
            core.pulse(u);
            @(posedge clk);
            check(flg[u], 1'b0);
         end
      end
      $display("done: timer modes");
      core.wr(8'h89, 8'h55);
      for (int u = 0; u < 2; u++) begin
         core.wr(8'(8'h8a + u), 8'hfe);
         core.wr(8'(8'h8c + u), 8'hff);
      end
      core.wr(8'h88, 8'h50);
      for (int k = 0; k < 2; k++) begin
         count_pin0 <= 1'b0;
         count_pin1 <= 1'b0;
         repeat (2 * OSC) @(posedge clk);
         count_pin0 <= 1'b1;
         count_pin1 <= 1'b1;
         repeat (3 * OSC) @(posedge clk);
         for (int u = 0; u < 2; u++) begin
            core.rd(8'(8'h8a + u), rv);
            check(rv, k ? 8'h00 : 8'hff);
         end
      end
      core.wr(8'h88, 8'h00);
      check(flg[0], 1'b1);
      check(flg[1], 1'b1);
      core.pulse(0);
      core.pulse(1);
      $display("done: counter");
      core.wr(8'h89, 8'h09);
      core.wr(8'h8a, 8'hfe);
      core.wr(8'h8c, 8'hff);
      ext_irq_in0 <= 1'b0;
      core.wr(8'h88, 8'h10);
      repeat (5 * OSC) @(posedge clk);
      check(flg[0], 1'b0);
      check(flg[2], 1'b1);
      ext_irq_in0 <= 1'b1;
      wait_flag(0, 3 * OSC, n);
      core.wr(8'h88, 8'h00);
      check(flg[0], 1'b1);
      core.pulse(0);
      core.pulse(2);
      @(posedge clk);
      check(flg[2], 1'b0);
      $display("done: gate");
      core.wr(8'h8b, 8'hab);
      core.wr(8'h89, 8'h30);
      core.wr(8'h88, 8'h40);
      repeat (3 * OSC) @(posedge clk);
      core.rd(8'h8b, rv);
      check(rv, 8'hab);
      core.wr(8'h8c, 8'hff);
      core.wr(8'h89, 8'h33);
      wait_flag(1, 2 * OSC, n);
      check(flg[1], 1'b1);
      core.rd(8'h8b, rv);
      check(rv, 8'hab);
      core.wr(8'h89, 8'h03);
      repeat (3 * OSC) @(posedge clk);
      core.rd(8'h8b, rv);
      check(8'(rv != 8'hab), 8'h01);
      core.wr(8'h88, 8'h00);
      core.wr(8'h89, 8'h00);
      core.pulse(1);
      $display("done: split");
      core.wr(8'h88, 8'h04);
      ext_irq_in1 <= 1'b0;
      repeat (8) @(posedge clk);
      check(flg[3], 1'b1);
      core.pulse(3);
      @(posedge clk);
      check(flg[3], 1'b0);
      core.wr(8'h88, 8'h00);
      repeat (5) @(posedge clk);
      check(flg[3], 1'b1);
      ext_irq_in1 <= 1'b1;
      repeat (5) @(posedge clk);
      core.pulse(3);
      @(posedge clk);
      check(flg[3], 1'b0);
      $display("done: external flags");
      close_out();
   end
endmodule

// ==== logic/dtc_consts.svh ====
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// register addresses on the special function register bus
`define DTC_ADDR_CONTROL   8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_U0_LOW    8'h8a
`define DTC_ADDR_U1_LOW    8'h8b
`define DTC_ADDR_U0_HIGH   8'h8c
`define DTC_ADDR_U1_HIGH   8'h8d

// reset values
`define DTC_CONTROL_RESET  8'h00
`define DTC_MODE_RESET     8'h00
`define DTC_COUNT_RESET    8'h00

// bit positions in timer_control
`define DTC_CTL_U1_OVF     7
`define DTC_CTL_U1_RUN     6
`define DTC_CTL_U0_OVF     5
`define DTC_CTL_U0_RUN     4
`define DTC_CTL_X1_FLAG    3
`define DTC_CTL_X1_TYPE    2
`define DTC_CTL_X0_FLAG    1
`define DTC_CTL_X0_TYPE    0

// field positions in timer_mode (unit 1 high nibble, unit 0 low nibble)
`define DTC_MOD_U1_GATE    7
`define DTC_MOD_U1_FUNC    6
`define DTC_MOD_U1_MHI     5
`define DTC_MOD_U1_MLO     4
`define DTC_MOD_U0_GATE    3
`define DTC_MOD_U0_FUNC    2
`define DTC_MOD_U0_MHI     1
`define DTC_MOD_U0_MLO     0

// oscillator periods per count or sample period
`define DTC_OSC_DIV        12

`endif

// ==== logic/dtc_pkg.sv ====
package dtc_pkg;

   // operating modes of a unit
   typedef enum logic [1:0] {
      dtc_mode_13bit = 2'h0,   // 8-bit high byte with 5-bit prescaler
      dtc_mode_16bit = 2'h1,   // cascaded 16-bit count
      dtc_mode_reload = 2'h2,  // 8-bit low byte with auto-reload
      dtc_mode_split = 2'h3    // split (unit 0) or halt (unit 1)
   } dtc_mode_t;

endpackage

// ==== logic/dtc_sync.sv ====
`timescale 1ns/100ps
// two-stage synchroniser for pin inputs; idles high after reset
module dtc_sync #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             clk,  // oscillator clock
   input  wire logic             rst,  // synchronous reset, active high
   input  wire logic [WIDTH-1:0] din,  // asynchronous pin levels
   output logic      [WIDTH-1:0] dout  // synchronised pin levels
);

   logic [WIDTH-1:0] stage1;  // first stage, read only by second

   // two flip-flops per pin before any logic looks at it
   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= '1;
         dout   <= '1;
      end else begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule

// ==== logic/dtc_timer_top.sv ====
// Notes on behaviour
// [R1] unit-1 overflow flag, bit 7, read-only, auto-cleared
// [R2] bit 6 runs unit 1
// [R3] unit-0 overflow flag, bit 5, read-only, auto-cleared
// [R4] bit 4 runs unit 0
// [R5] bit 3 external input 1 flag, read-only
// [R6] bit 2: input 1 falling edge or low level
// [R7] bit 1 external input 0 flag, read-only
// [R8] bit 0: input 0 falling edge or low level
// [R9] mode 0: 13-bit count, high byte plus five
// [R10] rollover to zero sets the overflow flag
// [R11] count only when run and (no gate or pin high)
// [R12] setting run keeps existing count bytes
// [R13] mode 1: full 16-bit cascaded count
// [R14] mode 2: low byte reloads from high byte
// [R15] unit 1 mode 3 holds like run off
// [R16] unit 0 mode 3 low byte uses unit-0 controls
// [R17] unit 0 mode 3 high byte: timer, unit-1 run/flag
// [R18] unit 1 switched by entering or leaving mode 3
// [R19] mode register: function select and mode field
// [R20] timer counts once per twelve oscillator periods
// [R21] counter counts sampled one-then-zero on next sample
// [R22] function select 0 timer, 1 external pin
// [R23] acknowledge pulse clears the matching flag
`timescale 1ns/100ps
`include "dtc_consts.svh"
module dtc_timer_top #(
   parameter int unsigned OSC_DIV = `DTC_OSC_DIV  // clocks per sample period
) (
   input  wire logic       clk,                  // oscillator, 50 MHz
   input  wire logic       rst,                  // sync reset, active high
   input  wire logic [7:0] sfr_addr,             // register address
   input  wire logic       sfr_wr,               // write strobe
   input  wire logic       sfr_rd,               // read strobe
   input  wire logic [7:0] sfr_wdata,            // write data
   output logic      [7:0] sfr_rdata,            // registered read data
   input  wire logic       count_pin0,           // unit-0 external count pin
   input  wire logic       count_pin1,           // unit-1 external count pin
   input  wire logic       ext_irq_in0,          // external interrupt pin 0
   input  wire logic       ext_irq_in1,          // external interrupt pin 1
   input  wire logic       ack_unit0,            // unit-0 interrupt serviced
   input  wire logic       ack_unit1,            // unit-1 interrupt serviced
   input  wire logic       ack_ext0,             // ext 0 interrupt serviced
   input  wire logic       ack_ext1,             // ext 1 interrupt serviced
   output logic            unit0_overflow_flag,  // unit-0 overflow request
   output logic            unit1_overflow_flag,  // unit-1 overflow request
   output logic            ext_irq0_flag,        // ext 0 request
   output logic            ext_irq1_flag         // ext 1 request
);

   // refuse dividers the 8-bit prescaler cannot serve
   if (OSC_DIV < 2 || OSC_DIV > 255) begin : g_bad_div
      $error("dtc_timer_top: OSC_DIV must be 2 to 255");
   end

   // control bits
   logic       unit0_run;              // unit-0 run control
   logic       unit1_run;              // unit-1 run control
   logic       ext_irq0_trigger_type;  // 1 falling edge, 0 low level
   logic       ext_irq1_trigger_type;  // 1 falling edge, 0 low level
   logic [7:0] timer_mode;             // gate, function and mode fields

   // count bytes
   logic [7:0] unit0_low_byte;   // unit-0 low count byte
   logic [7:0] unit0_high_byte;  // unit-0 high count byte
   logic [7:0] unit1_low_byte;   // unit-1 low count byte
   logic [7:0] unit1_high_byte;  // unit-1 high count byte

   // prescaler
   logic [7:0] div_cnt;  // oscillator periods within a sample period
   logic       tick;     // one pulse per sample period

   // synchronised pins: {ext1, ext0, count1, count0}
   logic [3:0] pins_s;    // pin levels after two flip-flops
   logic [1:0] gate;      // gate bits per unit
   logic [1:0] func;      // function select per unit
   logic [1:0] samp;      // last sample of each count pin
   logic [1:0] fall;      // one-then-zero seen, count at next sample
   logic [1:0] event_in;  // count event per unit
   logic [1:0] ext_prev;  // previous level of each external pin

   // decoded modes and stepping results
   dtc_pkg::dtc_mode_t mode0;  // unit-0 mode
   dtc_pkg::dtc_mode_t mode1;  // unit-1 mode
   logic [16:0] step0;         // unit-0 next count with carry
   logic [16:0] step1;         // unit-1 next count with carry
   logic        en0;           // unit-0 counts this cycle
   logic        en1;           // unit-1 counts this cycle
   logic        en0_high;      // split unit-0 high byte counts
   logic        split;         // unit 0 in mode 3
   logic        ovf0_set;      // sets unit-0 overflow flag
   logic        ovf1_set;      // sets unit-1 overflow flag
   logic [1:0]  ext_set;       // sets external flags

   // bus write decode
   logic wr_ctl;  // write to timer_control
   logic wr_mod;  // write to timer_mode

   // advance one count step in the given mode; bit 16 is the rollover
   function automatic logic [16:0] dtc_step(
      input dtc_pkg::dtc_mode_t mode,
      input logic [7:0]         hi,
      input logic [7:0]         lo
   );
      logic [12:0] c13;  // 13-bit sum
      logic [15:0] c16;  // 16-bit sum
      logic [16:0] r;    // result
      c13 = 13'({hi, lo[4:0]} + 13'h0001);
      c16 = 16'({hi, lo} + 16'h0001);
      r   = {1'b0, hi, lo};
      unique case (mode)
         // 13 bits; the top three low-byte bits are left alone
         dtc_pkg::dtc_mode_13bit: begin
            r = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};  // R9 R10
         end
         // full 16 bits
         dtc_pkg::dtc_mode_16bit: begin
            r = {&{hi, lo}, c16};  // R13 R10
         end
         // low byte reloads from high byte on rollover
         dtc_pkg::dtc_mode_reload: begin
            if (&lo) begin
               r = {1'b1, hi, hi};  // R14
            end else begin
               r = {1'b0, hi, 8'(lo + 8'h01)};  // R14
            end
         end
         // split: low byte alone as an 8-bit counter
         dtc_pkg::dtc_mode_split: begin
            r = {&lo, hi, 8'(lo + 8'h01)};  // R16
         end
      endcase
      return r;
   endfunction

   // pins pass two flip-flops before use
   dtc_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk  (clk),
      .rst  (rst),
      .din  ({ext_irq_in1, ext_irq_in0, count_pin1, count_pin0}),
      .dout (pins_s)
   );

   // field decode of timer_mode
   assign gate  = {timer_mode[`DTC_MOD_U1_GATE], timer_mode[`DTC_MOD_U0_GATE]};
   assign func  = {timer_mode[`DTC_MOD_U1_FUNC], timer_mode[`DTC_MOD_U0_FUNC]};
   assign mode0 = dtc_pkg::dtc_mode_t'(
                  timer_mode[`DTC_MOD_U0_MHI:`DTC_MOD_U0_MLO]);  // R19
   assign mode1 = dtc_pkg::dtc_mode_t'(
                  timer_mode[`DTC_MOD_U1_MHI:`DTC_MOD_U1_MLO]);  // R19
   assign split = (mode0 == dtc_pkg::dtc_mode_split);
   assign wr_ctl = sfr_wr && (sfr_addr == `DTC_ADDR_CONTROL);
   assign wr_mod = sfr_wr && (sfr_addr == `DTC_ADDR_MODE);

   // prescaler: one tick every OSC_DIV oscillator periods
   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt <= 8'h00;
         tick    <= 1'b0;
      end else if (div_cnt == 8'(OSC_DIV - 1)) begin
         div_cnt <= 8'h00;
         tick    <= 1'b1;  // R20
      end else begin
         div_cnt <= 8'(div_cnt + 8'h01);
         tick    <= 1'b0;
      end
   end

   // per-unit pin sampling and count event selection
   for (genvar i = 0; i < 2; i++) begin : g_unit
      // sample the count pin once per tick and remember a fall
      always_ff @(posedge clk) begin
         if (rst) begin
            samp[i] <= 1'b1;
            fall[i] <= 1'b0;
         end else if (tick) begin
            samp[i] <= pins_s[i];               // R21
            fall[i] <= samp[i] & ~pins_s[i];    // R21
         end
      end
      // timer counts every tick, counter on the tick after a fall
      assign event_in[i] = tick & (func[i] ? fall[i] : 1'b1);  // R22 R20 R21
   end

   // count enables, gated by run bit and external pin, except unit 1 under split (no run bit) and split high byte (unit-1 run only)
   always_comb begin
      en0      = event_in[0] & unit0_run
                 & (~gate[0] | pins_s[2]);  // R11 R4 R16
      en0_high = split & tick & unit1_run;  // R17
      // unit 1 is held in mode 3; under split its run bit is taken away
      en1      = event_in[1] & (split ? 1'b1 : unit1_run)
                 & (mode1 != dtc_pkg::dtc_mode_split)
                 & (~gate[1] | pins_s[3]);  // R11 R2 R15 R18
      step0    = dtc_step(mode0, unit0_high_byte, unit0_low_byte);
      step1    = dtc_step(mode1, unit1_high_byte, unit1_low_byte);
      ovf0_set = en0 & step0[16];  // R10
      // under split the unit-1 flag belongs to unit-0 high byte
      ovf1_set = split ? (en0_high & (&unit0_high_byte))
                       : (en1 & step1[16]);  // R17 R18 R10
   end

   // unit-0 count bytes; a bus write wins over counting
   always_ff @(posedge clk) begin
      if (rst) begin
         unit0_low_byte  <= `DTC_COUNT_RESET;
         unit0_high_byte <= `DTC_COUNT_RESET;
      end else begin
         if (en0) begin
            unit0_low_byte <= step0[7:0];
            if (!split) begin
               unit0_high_byte <= step0[15:8];
            end
         end
         // split high byte counts as a timer alone
         if (en0_high) begin
            unit0_high_byte <= 8'(unit0_high_byte + 8'h01);  // R17
         end
         if (sfr_wr && sfr_addr == `DTC_ADDR_U0_LOW) begin
            unit0_low_byte <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == `DTC_ADDR_U0_HIGH) begin
            unit0_high_byte <= sfr_wdata;
         end
      end
   end

   // unit-1 count bytes; held when disabled, never cleared by run
   always_ff @(posedge clk) begin
      if (rst) begin
         unit1_low_byte  <= `DTC_COUNT_RESET;
         unit1_high_byte <= `DTC_COUNT_RESET;
      end else begin
         if (en1) begin
            {unit1_high_byte, unit1_low_byte} <= step1[15:0];  // R12
         end
         if (sfr_wr && sfr_addr == `DTC_ADDR_U1_LOW) begin
            unit1_low_byte <= sfr_wdata;
         end
         if (sfr_wr && sfr_addr == `DTC_ADDR_U1_HIGH) begin
            unit1_high_byte <= sfr_wdata;
         end
      end
   end

   // writable control bits; flags ignore bus writes
   always_ff @(posedge clk) begin
      if (rst) begin
         unit1_run             <= 1'(`DTC_CONTROL_RESET >> `DTC_CTL_U1_RUN);
         unit0_run             <= 1'(`DTC_CONTROL_RESET >> `DTC_CTL_U0_RUN);
         ext_irq1_trigger_type <= 1'(`DTC_CONTROL_RESET >> `DTC_CTL_X1_TYPE);
         ext_irq0_trigger_type <= 1'(`DTC_CONTROL_RESET >> `DTC_CTL_X0_TYPE);
      end else if (wr_ctl) begin
         unit1_run             <= sfr_wdata[`DTC_CTL_U1_RUN];   // R2 R12
         unit0_run             <= sfr_wdata[`DTC_CTL_U0_RUN];   // R4 R12
         ext_irq1_trigger_type <= sfr_wdata[`DTC_CTL_X1_TYPE];  // R6
         ext_irq0_trigger_type <= sfr_wdata[`DTC_CTL_X0_TYPE];  // R8
      end
   end

   // mode register, fully read/write
   always_ff @(posedge clk) begin
      if (rst) begin
         timer_mode <= `DTC_MODE_RESET;
      end else if (wr_mod) begin
         timer_mode <= sfr_wdata;  // R19
      end
   end

   // external pin condition: falling edge or low level
   always_comb begin
      ext_set[0] = ext_irq0_trigger_type ? (ext_prev[0] & ~pins_s[2])
                                         : ~pins_s[2];  // R8
      ext_set[1] = ext_irq1_trigger_type ? (ext_prev[1] & ~pins_s[3])
                                         : ~pins_s[3];  // R6
   end

   // remember external pin levels for edge detection
   always_ff @(posedge clk) begin
      if (rst) begin
         ext_prev <= 2'h3;
      end else begin
         ext_prev <= pins_s[3:2];
      end
   end

   // sticky flags: set by hardware, cleared by acknowledge, set wins
   always_ff @(posedge clk) begin
      if (rst) begin
         unit0_overflow_flag <= 1'b0;
         unit1_overflow_flag <= 1'b0;
         ext_irq0_flag       <= 1'b0;
         ext_irq1_flag       <= 1'b0;
      end else begin
         unit0_overflow_flag <= ovf0_set
                                | (unit0_overflow_flag & ~ack_unit0);  // R3 R23
         unit1_overflow_flag <= ovf1_set
                                | (unit1_overflow_flag & ~ack_unit1);  // R1 R23
         ext_irq0_flag       <= ext_set[0]
                                | (ext_irq0_flag & ~ack_ext0);  // R7 R23
         ext_irq1_flag       <= ext_set[1]
                                | (ext_irq1_flag & ~ack_ext1);  // R5 R23
      end
   end

   // registered read port; unmapped addresses and idle cycles read zero
   always_ff @(posedge clk) begin
      if (rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            `DTC_ADDR_CONTROL: begin
               sfr_rdata <= {unit1_overflow_flag, unit1_run,
                             unit0_overflow_flag, unit0_run,
                             ext_irq1_flag, ext_irq1_trigger_type,
                             ext_irq0_flag, ext_irq0_trigger_type};
            end
            `DTC_ADDR_MODE:    sfr_rdata <= timer_mode;
            `DTC_ADDR_U0_LOW:  sfr_rdata <= unit0_low_byte;
            `DTC_ADDR_U1_LOW:  sfr_rdata <= unit1_low_byte;
            `DTC_ADDR_U0_HIGH: sfr_rdata <= unit0_high_byte;
            `DTC_ADDR_U1_HIGH: sfr_rdata <= unit1_high_byte;
            default:           sfr_rdata <= 8'h00;
         endcase
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

endmodule
